// ---- common/tsim_flag_if.sv ----
// carrier between the register front end and a sticky flag bank
// assumes: both ends on the same clock
`timescale 1ns/10ps
`default_nettype none
interface tsim_flag_if #(parameter int W = 8);
  logic [W-1:0] set;      // hardware set vector, a one-cycle pulse or a held level per event
  logic [W-1:0] mask;     // enable per flag, 1 = interrupt enabled
  logic rdClear;          // software read of this register
  logic [W-1:0] flags;    // sticky flags
  logic pending;          // some enabled flag is set

  modport bank (input set, input mask, input rdClear,
                output flags, output pending);
  modport ctrl (output set, output mask, output rdClear,
                input flags, input pending);
endinterface // tsim_flag_if
`default_nettype wire

// ---- common/tsim_pkg.sv ----
// constants for the t1 status and interrupt-mask block
// assumes: 32-bit axi4-lite register bus, one 125 MHz clock domain
//
// Notes on behaviour
// - match flag when received byte equals either compare
// - empty flag when transmit holding buffer becomes empty
// - status two readable at index 0x21
// - mask one at index 0x7f gates status one
// - mask zero blocks interrupt, flag still records
// - mask one lets a set flag raise interrupt
// - mask two at index 0x6f gates status two
// - unaligned flag set while framer lacks alignment
package tsim_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_STATUS_ONE = 8'h20;  // alarm flags
  localparam logic [7:0] IDX_STATUS_TWO = 8'h21;  // event flags
  localparam logic [7:0] IDX_MASK_TWO = 8'h6f;    // event_interrupt_enable
  localparam logic [7:0] IDX_MASK_ONE = 8'h7f;    // alarm_interrupt_enable
  localparam logic [7:0] IDX_COMPARE_A = 8'h60;   // datalink_compare_a
  localparam logic [7:0] IDX_COMPARE_B = 8'h61;   // datalink_compare_b

  // address shape: byte lanes dropped, index bits above them
  localparam int ADDR_LSB = 2;
  localparam int IDX_BITS = 8;
  localparam int FLAG_BITS = 8;

  // status one bit positions
  localparam int B_LOOPUP = 7;          // loopup_code_seen
  localparam int B_LOOPDOWN = 6;        // loopdown_code_seen
  localparam int B_TXCLKLOST = 5;       // tx_clock_lost
  localparam int B_SLIP = 4;            // elastic store slip
  localparam int B_ALLONES = 3;         // rx_all_ones_alarm
  localparam int B_REMOTE = 2;          // rx_remote_alarm
  localparam int B_CARRIER = 1;         // rx_carrier_lost
  localparam int B_UNALIGNED = 0;       // rx_frame_unaligned

  // status two bit positions
  localparam int B_RXMF = 7;            // rx_multiframe_boundary
  localparam int B_TXMF = 6;            // tx_multiframe_boundary
  localparam int B_SECOND = 5;          // one_second_tick
  localparam int B_RXFULL = 4;          // rx_datalink_full
  localparam int B_TXEMPTY = 3;         // tx_datalink_empty
  localparam int B_MATCH = 2;           // rx_datalink_match
  localparam int B_ABORT = 1;           // rx_datalink_abort
  localparam int B_ROBBED = 0;          // robbed_bit_change

  // reset values
  localparam logic [7:0] RST_MASK = 8'h00;
  localparam logic [7:0] RST_COMPARE = 8'h00;
  localparam logic [7:0] RST_FLAGS = 8'h00;

  // axi response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

endpackage

// ---- design/tsim_flag_bank.sv ----
// sticky flag bank with read-to-clear and per-bit enable
// assumes: set and rdClear are synchronous pulses or levels on clk
`timescale 1ns/10ps
`default_nettype none
module tsim_flag_bank #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic nrst,
  tsim_flag_if.bank fb
);
  import tsim_pkg::*;

  logic [W-1:0] next_flags;  // flags after this edge

  // refuse an empty bank
  if (W < 1) begin : g_check
    $error("flag bank width must be at least one");
  end

  // set wins over a read clear so no event is lost in that cycle
  always_comb begin
    next_flags = (fb.flags & ~{W{fb.rdClear}}) | fb.set;
  end

  // flags register
  always_ff @(posedge clk) begin
    if (!nrst) begin
      fb.flags <= '0;
    end else begin
      fb.flags <= next_flags;
    end
  end

  // a cleared mask bit still lets the flag record
  always_comb begin
    fb.pending = |(fb.flags & fb.mask);
  end

endmodule // tsim_flag_bank
`default_nettype wire

// ---- design/tsim_status_irq.sv ----
// status flags, interrupt masks and datalink compare of a t1 framer
// assumes: event inputs come from logic on clk, so no synchronisers;
// assumes: an axi4-lite master on clk, one write and one read at a time
`timescale 1ns/10ps
`default_nettype none
module tsim_status_irq #(
  parameter int AW = 10
) (
  input wire logic clk,
  input wire logic nrst,
  // axi4-lite slave
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // alarm levels, laid out as status one
  input wire logic [tsim_pkg::FLAG_BITS-1:0] alarmLevel,
  // event pulses from framer and datalink logic
  input wire logic rxMultiframeBoundary,
  input wire logic txMultiframeBoundary,
  input wire logic oneSecondTick,
  input wire logic rxDatalinkFull,
  input wire logic txDatalinkEmpty,
  input wire logic rxDatalinkAbort,
  input wire logic robbedBitChange,
  input wire logic [7:0] rxDatalinkByte,
  input wire logic rxDatalinkValid,
  // interrupt request, active high level
  output logic irq
);
  import tsim_pkg::*;

  // the decode needs the full index above the byte lanes
  if (AW < ADDR_LSB + IDX_BITS) begin : g_check
    $error("address width too small for the register map");
  end

  tsim_flag_if #(.W(FLAG_BITS)) statusOne ();  // alarm flags
  tsim_flag_if #(.W(FLAG_BITS)) statusTwo ();  // event flags

  logic [7:0] maskOne;      // alarm_interrupt_enable
  logic [7:0] maskTwo;      // event_interrupt_enable
  logic [7:0] compareA;     // datalink_compare_a
  logic [7:0] compareB;     // datalink_compare_b
  logic txEmptyPrev;        // last sample of the empty level
  logic [IDX_BITS-1:0] wrIdx;  // held write index
  logic wrHigh;             // held write address above the map
  logic [7:0] wrData;       // held low write byte
  logic wrStrb;             // held lane-0 strobe
  logic wrFire;             // both halves held, do the write
  logic wrHit;              // write address maps a register
  logic rdFire;             // read address taken this edge
  logic [IDX_BITS-1:0] rdIdx;  // index of the read address
  logic rdHit;              // read address maps a register
  logic [7:0] rdValue;      // byte returned for the read
  logic matchNow;           // received byte hits a compare value
  logic txEmptyEdge;        // buffer just became empty

  // flag banks, one per status register
  tsim_flag_bank #(.W(FLAG_BITS)) u_bankOne (
    .clk(clk),
    .nrst(nrst),
    .fb(statusOne.bank)
  );
  tsim_flag_bank #(.W(FLAG_BITS)) u_bankTwo (
    .clk(clk),
    .nrst(nrst),
    .fb(statusTwo.bank)
  );

  // compare either programmable value against a received byte
  always_comb begin
    matchNow = rxDatalinkValid &&
      (rxDatalinkByte == compareA || rxDatalinkByte == compareB);
    txEmptyEdge = txDatalinkEmpty && !txEmptyPrev;
  end

  // level history for the empty edge; reset low so an empty buffer
  // out of reset reports once
  always_ff @(posedge clk) begin
    if (!nrst) begin
      txEmptyPrev <= 1'b0;
    end else begin
      txEmptyPrev <= txDatalinkEmpty;
    end
  end

  // alarm levels keep re-setting their flag while they last
  assign statusOne.set = alarmLevel;
  assign statusOne.mask = maskOne;
  assign statusTwo.mask = maskTwo;
  assign statusTwo.set = {rxMultiframeBoundary, txMultiframeBoundary,
                          oneSecondTick, rxDatalinkFull, txEmptyEdge,
                          matchNow, rxDatalinkAbort, robbedBitChange};

  // read of a status register clears it as the value is captured
  always_comb begin
    rdFire = s_axi_arvalid && s_axi_arready;
    rdIdx = s_axi_araddr[ADDR_LSB +: IDX_BITS];
    statusOne.rdClear = rdFire && rdHit && rdIdx == IDX_STATUS_ONE;
    statusTwo.rdClear = rdFire && rdHit && rdIdx == IDX_STATUS_TWO;
  end

  // read decode; unmapped reads return zero with decerr
  always_comb begin
    rdHit = (s_axi_araddr >> (ADDR_LSB + IDX_BITS)) == '0;
    rdValue = 8'h00;
    if (!rdHit) begin
      rdValue = 8'h00;
    end else if (rdIdx == IDX_STATUS_ONE) begin
      rdValue = statusOne.flags;
    end else if (rdIdx == IDX_STATUS_TWO) begin
      rdValue = statusTwo.flags;
    end else if (rdIdx == IDX_MASK_ONE) begin
      rdValue = maskOne;
    end else if (rdIdx == IDX_MASK_TWO) begin
      rdValue = maskTwo;
    end else if (rdIdx == IDX_COMPARE_A) begin
      rdValue = compareA;
    end else if (rdIdx == IDX_COMPARE_B) begin
      rdValue = compareB;
    end else begin
      rdHit = 1'b0;
    end
  end

  // read channel: one read in flight, arready drops until rdata taken
  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (rdFire) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h00_0000, rdValue};
      s_axi_rresp <= rdHit ? RESP_OKAY : RESP_DECERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
    end
  end

  // write address and data are taken in either order and held
  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      wrIdx <= '0;
      wrHigh <= 1'b0;
      wrData <= 8'h00;
      wrStrb <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        wrIdx <= s_axi_awaddr[ADDR_LSB +: IDX_BITS];
        wrHigh <= (s_axi_awaddr >> (ADDR_LSB + IDX_BITS)) != '0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        wrData <= s_axi_wdata[7:0];
        wrStrb <= s_axi_wstrb[0];
      end
    end
  end

  // the write lands once both halves are held and no response waits
  always_comb begin
    wrFire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
    wrHit = !wrHigh && (wrIdx == IDX_STATUS_ONE ||
      wrIdx == IDX_STATUS_TWO || wrIdx == IDX_MASK_ONE ||
      wrIdx == IDX_MASK_TWO || wrIdx == IDX_COMPARE_A ||
      wrIdx == IDX_COMPARE_B);
  end

  // write response; status registers ignore writes but answer okay
  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wrFire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wrHit ? RESP_OKAY : RESP_DECERR;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // writable registers, only the low byte lane carries data
  always_ff @(posedge clk) begin
    if (!nrst) begin
      maskOne <= RST_MASK;
      maskTwo <= RST_MASK;
      compareA <= RST_COMPARE;
      compareB <= RST_COMPARE;
    end else if (wrFire && wrStrb && !wrHigh) begin
      if (wrIdx == IDX_MASK_ONE) begin
        maskOne <= wrData;
      end else if (wrIdx == IDX_MASK_TWO) begin
        maskTwo <= wrData;
      end else if (wrIdx == IDX_COMPARE_A) begin
        compareA <= wrData;
      end else if (wrIdx == IDX_COMPARE_B) begin
        compareB <= wrData;
      end
    end
  end

  // registered request, one cycle behind the flags
  always_ff @(posedge clk) begin
    if (!nrst) begin
      irq <= 1'b0;
    end else begin
      irq <= statusOne.pending | statusTwo.pending;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence sMatchA;
    rxDatalinkValid && rxDatalinkByte == compareA;
  endsequence
  sequence sReadTwo;
    rdFire && rdIdx == IDX_STATUS_TWO && rdHit;
  endsequence
  sequence sWriteOne;
    wrFire && wrStrb && !wrHigh && wrIdx == IDX_MASK_ONE;
  endsequence
  sequence sWriteTwo;
    wrFire && wrStrb && !wrHigh && wrIdx == IDX_MASK_TWO;
  endsequence
  sequence sAllQuiet;
    (statusOne.flags & maskOne) == 8'h00 &&
    (statusTwo.flags & maskTwo) == 8'h00;
  endsequence
  sequence sMatchB;
    rxDatalinkValid && rxDatalinkByte == compareB;
  endsequence
  sequence sClearTwo;
    rdFire && rdHit && rdIdx == IDX_STATUS_TWO && statusTwo.set == 8'h00;
  endsequence

  chk_match_sets_flag: assert property (
    sMatchA |=> statusTwo.flags[B_MATCH])
    else $error("compare hit did not set match flag");
  chk_empty_edge_flag: assert property (
    txDatalinkEmpty && !$past(txDatalinkEmpty) |=>
      statusTwo.flags[B_TXEMPTY])
    else $error("buffer empty edge did not set flag");
  chk_status_two_read: assert property (
    sReadTwo |=> s_axi_rvalid &&
      s_axi_rdata == {24'h00_0000, $past(statusTwo.flags)})
    else $error("status two read returned wrong value");
  chk_mask_one_write: assert property (
    sWriteOne |=> maskOne == $past(wrData) && s_axi_bvalid)
    else $error("mask one write not stored");
  chk_masked_no_irq: assert property (
    sAllQuiet |=> !irq)
    else $error("interrupt raised with no enabled flag");
  chk_enabled_irq: assert property (
    (|(statusTwo.flags & maskTwo)) |=> irq)
    else $error("enabled flag did not raise interrupt");
  chk_mask_two_write: assert property (
    sWriteTwo |=> maskTwo == $past(wrData))
    else $error("mask two write not stored");
  chk_unaligned_flag: assert property (
    alarmLevel[B_UNALIGNED] |=> statusOne.flags[B_UNALIGNED])
    else $error("unaligned level did not set flag");
  chk_irq_holds: assert property (
    (|(statusOne.flags & maskOne))[*2] |-> irq)
    else $error("interrupt dropped while enabled flag set");
  // the second compare value matches as well as the first
  chk_match_b_flag: assert property (
    sMatchB |=> statusTwo.flags[B_MATCH])
    else $error("second compare hit did not set match flag");
  // a read with nothing arriving leaves the register empty
  chk_read_clears_two: assert property (
    sClearTwo |=> statusTwo.flags == 8'h00)
    else $error("status two read did not clear flags");
  // masked or not, every set event lands in its flag
  chk_flag_records: assert property (
    (|statusTwo.set) |=>
      (statusTwo.flags & $past(statusTwo.set)) == $past(statusTwo.set))
    else $error("event not recorded in status two");
  // an enabled alarm flag raises the request a cycle later
  chk_alarm_irq: assert property (
    (|(statusOne.flags & maskOne)) |=> irq)
    else $error("enabled alarm flag did not raise interrupt");

endmodule // tsim_status_irq
`default_nettype wire

// ---- verification/test_t1_status_interrupt_masks.sv ----
// testbench of the status flags and interrupt masks
// assumes: host model drives the register bus, bench drives event inputs
`timescale 1ns/10ps
`default_nettype none
module test_t1_status_interrupt_masks;
  import tsim_pkg::*;
  // byte addresses of the registers
  localparam logic [9:0] A_ST1 = {IDX_STATUS_ONE, 2'b00};
  localparam logic [9:0] A_ST2 = {IDX_STATUS_TWO, 2'b00};
  localparam logic [9:0] A_MSK1 = {IDX_MASK_ONE, 2'b00};
  localparam logic [9:0] A_MSK2 = {IDX_MASK_TWO, 2'b00};
  localparam logic [9:0] A_CMPA = {IDX_COMPARE_A, 2'b00};
  localparam logic [9:0] A_CMPB = {IDX_COMPARE_B, 2'b00};
  localparam logic [9:0] A_NONE = 10'h3f0; // unmapped index
  logic clk;
  logic nrst;
  logic [7:0] alarm; // alarm levels, status one layout
  logic [7:0] ev; // event pulses, status two layout
  logic [7:0] dlByte; // received datalink byte
  logic irq;
  logic [1:0] resp;
  logic [31:0] rdv;
  int errorCnt;
  int testsRun;
  int i;
  wire logic [9:0] awaddr, araddr;
  wire logic [31:0] wdata, rdata;
  wire logic [3:0] wstrb;
  wire logic [1:0] bresp, rresp;
  wire logic awvalid, awready, wvalid, wready, bvalid, bready;
  wire logic arvalid, arready, rvalid, rready;

  tsim_host_model host (.clk(clk), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready));

  tsim_status_irq #(.AW(10)) dut (.clk(clk), .nrst(nrst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .alarmLevel(alarm),
    .rxMultiframeBoundary(ev[B_RXMF]), .txMultiframeBoundary(ev[B_TXMF]),
    .oneSecondTick(ev[B_SECOND]), .rxDatalinkFull(ev[B_RXFULL]),
    .txDatalinkEmpty(ev[B_TXEMPTY]), .rxDatalinkAbort(ev[B_ABORT]),
    .robbedBitChange(ev[B_ROBBED]), .rxDatalinkByte(dlByte),
    .rxDatalinkValid(ev[B_MATCH]), .irq(irq));

  // 125 MHz clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // one comparison, counted
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    testsRun++;
    if (got !== exp) begin
      errorCnt++;
      $display("wrong value at %0t: %s got %h want %h", $time, what, got,
               exp);
    end
  endtask

  // read a register and compare data and response
  task automatic rdChk(input logic [9:0] a, input logic [31:0] exp,
                       input logic [1:0] er);
    host.rd(a, rdv, resp);
    chk(rdv, exp, "read data");
    chk({30'h0, resp}, {30'h0, er}, "read response");
  endtask

  // write a register, expecting an okay answer
  task automatic wrOk(input logic [9:0] a, input logic [7:0] d);
    host.wr(a, d, resp);
    chk({30'h0, resp}, {30'h0, RESP_OKAY}, "write response");
  endtask

  // one-cycle event pulse, then room for flag and irq to land
  task automatic pulse(input logic [7:0] v, input logic [7:0] b);
    @(posedge clk);
    ev <= v;
    dlByte <= b;
    @(posedge clk);
    ev <= 8'h00;
    repeat (2) @(posedge clk);
  endtask

  // let a level change settle into flags and irq
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic finalReport();
    $display("checks %0d, mismatches %0d", testsRun, errorCnt);
    if (errorCnt == 0 && testsRun > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // watchdog; the whole run needs a few hundred cycles
  initial begin
    #200000;
    errorCnt++;
    finalReport();
  end

  initial begin
    errorCnt = 0;
    testsRun = 0;
    nrst = 1'b0;
    alarm = 8'h00;
    ev = 8'h00;
    dlByte = 8'h00;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    // everything comes out of reset at zero
    rdChk(A_ST1, 32'h0, RESP_OKAY);
    rdChk(A_ST2, 32'h0, RESP_OKAY);
    rdChk(A_MSK1, 32'h0, RESP_OKAY);
    rdChk(A_MSK2, 32'h0, RESP_OKAY);
    rdChk(A_CMPA, 32'h0, RESP_OKAY);
    rdChk(A_CMPB, 32'h0, RESP_OKAY);
    chk({31'h0, irq}, 32'h0, "irq after reset");
    $display("test reset values done");
    // mask storage, read-only status, unmapped place
    wrOk(A_MSK1, 8'ha5);
    rdChk(A_MSK1, 32'ha5, RESP_OKAY);
    wrOk(A_MSK2, 8'h5a);
    rdChk(A_MSK2, 32'h5a, RESP_OKAY);
    wrOk(A_ST2, 8'hff);
    rdChk(A_ST2, 32'h0, RESP_OKAY);
    host.wr(A_NONE, 8'h11, resp);
    chk({30'h0, resp}, {30'h0, RESP_DECERR}, "unmapped write");
    rdChk(A_NONE, 32'h0, RESP_DECERR);
    $display("test register access done");
    // every event with its enable set raises irq; the read clears it
    wrOk(A_MSK2, 8'hff);
    wrOk(A_CMPA, 8'h3c);
    wrOk(A_CMPB, 8'hc3);
    for (i = 0; i < FLAG_BITS; i++) begin
      pulse(8'h01 << i, 8'h3c);
      chk({31'h0, irq}, 32'h1, "irq on enabled event");
      rdChk(A_ST2, 32'h1 << i, RESP_OKAY);
      settle(3);
      chk({31'h0, irq}, 32'h0, "irq after clear");
    end
    pulse(8'h01 << B_MATCH, 8'hc3);
    rdChk(A_ST2, 32'h04, RESP_OKAY);
    pulse(8'h01 << B_MATCH, 8'h55);
    rdChk(A_ST2, 32'h0, RESP_OKAY);
    $display("test enabled events done");
    // a masked flag records without irq; an enabled one still ORs in
    wrOk(A_MSK2, 8'hdf);
    pulse(8'h20, 8'h00);
    chk({31'h0, irq}, 32'h0, "irq while masked");
    rdChk(A_ST2, 32'h20, RESP_OKAY);
    pulse(8'ha0, 8'h00);
    chk({31'h0, irq}, 32'h1, "irq with one enabled");
    rdChk(A_ST2, 32'ha0, RESP_OKAY);
    $display("test masked events done");
    // a held empty level sets its flag once only
    @(posedge clk);
    ev <= 8'h08;
    settle(3);
    chk({31'h0, irq}, 32'h1, "irq on empty edge");
    rdChk(A_ST2, 32'h08, RESP_OKAY);
    rdChk(A_ST2, 32'h0, RESP_OKAY);
    @(posedge clk);
    ev <= 8'h00;
    $display("test empty level done");
    // alarm levels in status one, gated by the first mask
    wrOk(A_MSK1, 8'h01);
    @(posedge clk);
    alarm <= 8'h02;
    settle(3);
    chk({31'h0, irq}, 32'h0, "irq masked alarm");
    @(posedge clk);
    alarm <= 8'h03;
    settle(3);
    chk({31'h0, irq}, 32'h1, "irq unaligned");
    rdChk(A_ST1, 32'h03, RESP_OKAY);
    @(posedge clk);
    alarm <= 8'h00;
    settle(2);
    rdChk(A_ST1, 32'h03, RESP_OKAY);
    rdChk(A_ST1, 32'h0, RESP_OKAY);
    settle(3);
    chk({31'h0, irq}, 32'h0, "irq after alarm clear");
    $display("test alarm flags done");
    finalReport();
  end
endmodule // test_t1_status_interrupt_masks
`default_nettype wire

// ---- verification/tsim_host_model.sv ----
// axi4-lite master standing in for the host processor
// assumes: slave on clk, byte address is four times the register index
`timescale 1ns/10ps
`default_nettype none
module tsim_host_model (
  input wire logic clk,
  output logic [9:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  output logic [9:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready
);
  // bus idle from time zero
  initial begin
    awaddr = 10'h000;
    awvalid = 1'b0;
    wdata = 32'h0;
    wstrb = 4'h0;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = 10'h000;
    arvalid = 1'b0;
    rready = 1'b0;
  end

  // one write; address and data offered together, each dropped when taken
  task automatic wr(input logic [9:0] a, input logic [7:0] d,
                    output logic [1:0] resp);
    logic awOpen;
    logic wOpen;
    @(posedge clk);
    awOpen = 1'b1;
    wOpen = 1'b1;
    awaddr <= a; // register byte address
    wdata <= {24'h0, d};
    wstrb <= 4'h1;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge clk);
      if (awOpen && awready) begin
        awOpen = 1'b0;
        awvalid <= 1'b0;
        awaddr <= ~a; // released lines stop showing the target
      end
      if (wOpen && wready) begin
        wOpen = 1'b0;
        wvalid <= 1'b0;
        wdata <= ~{24'h0, d};
      end
      if (bvalid) begin
        resp = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask

  // one read; rready held from the start, so the answer edge ends it
  task automatic rd(input logic [9:0] a, output logic [31:0] d,
                    output logic [1:0] resp);
    logic arOpen;
    @(posedge clk);
    arOpen = 1'b1;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge clk);
      if (rvalid) begin
        d = rdata;
        resp = rresp;
        rready <= 1'b0;
        break;
      end
      if (arOpen && arready) begin
        arOpen = 1'b0;
        arvalid <= 1'b0;
        araddr <= ~a;
      end
    end
  endtask
endmodule // tsim_host_model
`default_nettype wire
